/* File: hdl/mgmt_serial_slave_port.v */
// serial management slave port: frame decoder and register access
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_serial_consts.vh"
// Function
// - five-bit device address selects one of 32
// - line released during idle, write turnaround and first read turnaround bit
// - ignore frames until 32-one preamble seen
// - frame starts with zero then one
// - start, opcode, addresses, turnaround, then data
// - nobody drives first read turnaround bit
// - device drives zero then read data
// - status register bit 6 reports suppression support
// - accept back-to-back frames once synchronised
// - sixteen-bit data field, thirty-two registers
module mgmt_serial_slave_port #(
  parameter PHY_ADDR = 5'h01
) (
  input wire CLK,
  input wire RST,
  input wire MDC,
  input wire MDIO_IN,
  output reg MDIO_OUT,
  output reg MDIO_OE_N,
  output reg [4:0] REG_ADDR,
  output reg [15:0] WR_DATA,
  output reg WR_STROBE,
  input wire [15:0] RD_DATA,
  output reg SYNCED
);
  localparam ST_PRE = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_TA = 3'd3;
  localparam ST_DATA = 3'd4;

  reg mdc_s1_ff, mdc_s2_ff, mdc_s3_ff;
  reg dio_s1_ff, dio_s2_ff;
  reg [2:0] state_ff;
  reg [5:0] cnt_ff;
  reg [13:0] hdr_ff;
  reg [15:0] shift_ff;
  reg is_read_ff;
  reg mine_ff;
  wire rise = mdc_s2_ff & ~mdc_s3_ff;
  wire fall = ~mdc_s2_ff & mdc_s3_ff;
  wire bit_in = dio_s2_ff;
  wire [13:0] hdr_nxt = {hdr_ff[12:0], bit_in};

  // pins cross into CLK domain through two flops
  always @(posedge CLK) begin
    mdc_s1_ff <= MDC;
    mdc_s2_ff <= mdc_s1_ff;
    mdc_s3_ff <= mdc_s2_ff;
    dio_s1_ff <= MDIO_IN;
    dio_s2_ff <= dio_s1_ff;
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_ff <= ST_PRE;
      cnt_ff <= 6'd0;
      hdr_ff <= 14'h0000;
      shift_ff <= 16'h0000;
      is_read_ff <= 1'b0;
      mine_ff <= 1'b0;
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b1;
      REG_ADDR <= 5'h00;
      WR_DATA <= 16'h0000;
      WR_STROBE <= 1'b0;
      SYNCED <= 1'b0;
    end else begin
      WR_STROBE <= 1'b0;
      if (rise) begin
        case (state_ff)
          ST_PRE: begin
            // count contiguous ones; any zero restarts
            if (!bit_in)
              cnt_ff <= 6'd0;
            else if (cnt_ff == `PREAMBLE_ONES - 6'd1) begin
              state_ff <= ST_IDLE;
              SYNCED <= 1'b1;
            end else
              cnt_ff <= cnt_ff + 6'd1;
          end
          ST_IDLE: begin
            // first zero is start bit; no preamble needed again
            if (!bit_in) begin
              state_ff <= ST_HDR;
              hdr_ff <= 14'h0000;
              cnt_ff <= 6'd1;
            end
          end
          ST_HDR: begin
            hdr_ff <= hdr_nxt;
            cnt_ff <= cnt_ff + 6'd1;
            if (cnt_ff == 6'd1 && !bit_in) begin
              state_ff <= ST_PRE;
              cnt_ff <= 6'd0;
              SYNCED <= 1'b0;
            end else if (cnt_ff == 6'd3 && hdr_nxt[1:0] != `OP_READ
                         && hdr_nxt[1:0] != `OP_WRITE) begin
              state_ff <= ST_PRE;
              cnt_ff <= 6'd0;
              SYNCED <= 1'b0;
            end else if (cnt_ff == 6'd13) begin
              // hdr_nxt: op[11:10] phy[9:5] reg[4:0]
              is_read_ff <= (hdr_nxt[11:10] == `OP_READ);
              mine_ff <= (hdr_nxt[9:5] == PHY_ADDR);
              REG_ADDR <= hdr_nxt[4:0];
              state_ff <= ST_TA;
              cnt_ff <= 6'd0;
            end
          end
          ST_TA: begin
            cnt_ff <= cnt_ff + 6'd1;
            if (cnt_ff == 6'd0) begin
              // first turnaround bit: line stays released
              if (!is_read_ff && !bit_in) begin
                // restart the preamble count from zero, not from the turnaround count
                state_ff <= ST_PRE;
                cnt_ff <= 6'd0;
                SYNCED <= 1'b0;
              end
            end else begin
              if (!is_read_ff && bit_in) begin
                state_ff <= ST_PRE;
                cnt_ff <= 6'd0;
                SYNCED <= 1'b0;
              end else begin
                state_ff <= ST_DATA;
                cnt_ff <= 6'd0;
                shift_ff <= RD_DATA;
                if (REG_ADDR == `STATUS_REG_ADDR)
                  shift_ff[`STATUS_SUPPR_BIT] <= 1'b1;
              end
            end
          end
          ST_DATA: begin
            cnt_ff <= cnt_ff + 6'd1;
            if (!is_read_ff)
              shift_ff <= {shift_ff[14:0], bit_in};
            if (cnt_ff == {1'b0, `DATA_BITS} - 6'd1) begin
              state_ff <= ST_IDLE;
              cnt_ff <= 6'd0;
              if (!is_read_ff && mine_ff) begin
                WR_DATA <= {shift_ff[14:0], bit_in};
                WR_STROBE <= 1'b1;
              end
            end
          end
          default: begin
            state_ff <= ST_PRE;
            cnt_ff <= 6'd0;
          end
        endcase
      end
      // drive after the falling edge so data is steady at the next rise
      if (fall) begin
        if (state_ff == ST_TA && cnt_ff == 6'd1 && is_read_ff && mine_ff) begin
          MDIO_OUT <= 1'b0;
          MDIO_OE_N <= 1'b0;
        end else if (state_ff == ST_DATA && is_read_ff && mine_ff) begin
          MDIO_OUT <= shift_ff[15 - cnt_ff[3:0]];
          MDIO_OE_N <= 1'b0;
        end else begin
          MDIO_OUT <= 1'b1;
          MDIO_OE_N <= 1'b1;
        end
      end
    end
  end
endmodule // mgmt_serial_slave_port
`default_nettype wire

/* File: hdl/mgmt_serial_consts.vh */
// constants for the serial management slave port
`ifndef MGMT_SERIAL_CONSTS_VH
`define MGMT_SERIAL_CONSTS_VH
`define PREAMBLE_ONES 6'd32
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define START_PAT 2'b01
`define DATA_BITS 5'd16
`define STATUS_REG_ADDR 5'h01
`define STATUS_SUPPR_BIT 6
`define HDR_BITS 5'd14
`endif

/* File: testbench/mgmt_serial_slave_port_sva.sv */
// checker for the serial management slave port
`timescale 1ns/1ps
`default_nettype none
module mgmt_serial_slave_port_sva (
  input wire CLK,
  input wire RST,
  input wire MDIO_OUT,
  input wire MDIO_OE_N,
  input wire [4:0] REG_ADDR,
  input wire WR_STROBE,
  input wire SYNCED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_pulse; WR_STROBE ##1 !WR_STROBE; endsequence
  AST_RST_IDLE: assert property ($fell(RST) |-> MDIO_OE_N && MDIO_OUT)
    else $error("line driven");
  AST_QUIET: assert property (!SYNCED |-> MDIO_OE_N)
    else $error("driven unsynced");
  AST_WR_SYNC: assert property (WR_STROBE |-> SYNCED)
    else $error("write unsynced");
  AST_PULSE: assert property (WR_STROBE |-> s_pulse)
    else $error("long strobe");
  AST_TA_ZERO: assert property ($fell(MDIO_OE_N) |-> !MDIO_OUT)
    else $error("ta not zero");
  AST_SPAN: assert property ($fell(MDIO_OE_N) |=> !MDIO_OE_N [*4])
    else $error("short drive");
  AST_ADDR: assert property (!MDIO_OE_N |-> $stable(REG_ADDR))
    else $error("address moved");
  AST_BIT: assert property (!MDIO_OE_N && $changed(MDIO_OUT) |=> $stable(MDIO_OUT) [*3])
    else $error("bit too short");
endmodule // mgmt_serial_slave_port_sva
bind mgmt_serial_slave_port mgmt_serial_slave_port_sva mgmt_serial_slave_port_sva_i (.*);
`default_nettype wire

/* File: testbench/mdio_station.sv */
// station model for the management link
`timescale 1ns/1ps
`default_nettype none
module mdio_station (
  output logic MDC,
  output logic sta_out,
  output logic sta_oe_n,
  output logic rdy,
  output logic [16:0] sh,
  input wire logic MDIO_IN
);
  initial {MDC, sta_out, sta_oe_n, rdy} = 4'h6;
  task automatic bt(input logic d, input logic drv);
    sta_out = d;
    sta_oe_n = !drv;
    #80 MDC = 1;
    sh = {sh[15:0], MDIO_IN};
    #80 MDC = 0;
  endtask
  task automatic pre(input int n);
    repeat (n) bt(1'h1, 1'h0);
  endtask
  task automatic frame(input logic [15:0] h, input logic [15:0] d);
    logic [31:0] w;
    w = {h, d};
    for (int i = 31; i >= 0; i--) bt(w[i], i > 17 || h[13:12] != 2'h2);
    rdy = h[13:12] == 2'h2 && !sh[16];
    #1 rdy = 0;
    bt(1'h1, 1'h0);
  endtask
endmodule // mdio_station
`default_nettype wire

/* File: testbench/mgmt_serial_slave_port_tb.sv */
// self-checking bench for the serial management slave port
`timescale 1ns/1ps
`default_nettype none
module mgmt_serial_slave_port_tb;
  logic CLK, RST, MDC, sta_out, sta_oe_n, rdy, MDIO_OUT, MDIO_OE_N, WR_STROBE, SYNCED, b;
  logic [4:0] REG_ADDR, rg, ph;
  logic [15:0] WR_DATA, RD_DATA;
  logic [16:0] sh;
  logic [31:0] r;
  logic [20:0] q[$];
  int fails = 0, total_checks = 0;
  wire MDIO_IN = (MDIO_OE_N | MDIO_OUT) & (sta_oe_n | sta_out);
  mgmt_serial_slave_port mgmt_serial_slave_port_i (.*);
  mdio_station mdio_station_i (.*);
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  task automatic ok(input logic c);
    total_checks++;
    if (!c) begin
      fails++;
      $display("Error %0t: mismatch", $time);
    end
  endtask
  task automatic chk(input logic [20:0] g);
    ok(q.size() > 0 && q[0] === g);
    if (q.size() > 0) void'(q.pop_front());
  endtask
  task automatic sync_is(input logic v);
    repeat (5) @(posedge CLK);
    ok(SYNCED === v);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge CLK) if (WR_STROBE === 1'h1) chk({REG_ADDR, WR_DATA});
  always @(posedge rdy) chk({REG_ADDR, sh[15:0]});
  initial begin
    #1900000;
    fails++;
    end_of_test;
  end
  initial begin
    RST = 1;
    RD_DATA = 16'h0000;
    r = $urandom(18158);
    repeat (8) @(posedge CLK);
    #1 RST = 0;
    mdio_station_i.frame(16'h508A, 16'h1234);
    sync_is(1'h0);
    mdio_station_i.pre(32);
    sync_is(1'h1);
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      rg = (i == 3) ? 5'h01 : r[4:0];
      ph = (i == 5 || i == 6) ? 5'h02 : 5'h01;
      b = r[5] | (i == 3) | (i == 6);
      @(posedge CLK);
      #1 RD_DATA = r[31:16];
      if (ph == 5'h01) q.push_back({rg, b ? r[31:16] | {9'h000, rg == 5'h01, 6'h00} : r[21:6]});
      mdio_station_i.frame({2'h1, b, !b, ph, rg, 2'h2}, r[21:6]);
    end
    $display("frames done");
    for (int i = 0; i < 3; i++) begin
      mdio_station_i.frame({1'h0, i != 0, i == 1, 1'h1, 10'h023, i != 2, 1'h0}, 16'hFFFF);
      sync_is(1'h0);
      mdio_station_i.frame(16'h508A, 16'h00FF);
      mdio_station_i.pre(32);
      q.push_back({5'h02, 16'hA5C3});
      mdio_station_i.frame(16'h508A, 16'hA5C3);
      $display("desync %0d done", i);
    end
    ok(q.size() == 0);
    end_of_test;
  end
endmodule // mgmt_serial_slave_port_tb
`default_nettype wire
